/* tcc_params.svh */
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_CAL_CFG_ADDR 8'h88
`define TCC_CAL_CFG_RESET 8'h00
`define TCC_BIT_FORCE_RECAL 3
`define TCC_BIT_MODE_HI 2
`define TCC_BIT_MODE_LO 1
`define TCC_BIT_SOFT_RESET 0
`define TCC_SOFT_RESET_CYCLES 4
`endif

/* tcc_pkg.sv */
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_MODE_AUTO = 2'h0,
		TCC_MODE_NOREF = 2'h1,
		TCC_MODE_REF = 2'h2,
		TCC_MODE_INVALID = 2'h3
	} tcc_osc_mode_t;
	typedef enum logic [2:0] {
		TCC_CAL_IDLE = 3'h1,
		TCC_CAL_ARM = 3'h2,
		TCC_CAL_WAIT = 3'h4
	} tcc_cal_state_t;
endpackage

/* tcc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	initial begin
		if (WIDTH < 1) $error("tcc_sync width must be at least one");
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= '0;
			dout <= '0;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule
`default_nettype wire

/* tcc_tx_cal_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tcc_params.svh"
module tcc_tx_cal_ctrl
	import tcc_pkg::*;
#(
	parameter int SOFT_RESET_CYCLES = `TCC_SOFT_RESET_CYCLES
) (
	// clock and power-on reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register port from the serial control logic
	input wire logic [7:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	output logic regRdValid,
	// timing mode from the transmit configuration logic
	input wire logic [2:0] timingSourceMode,
	// analog side status
	input wire logic refClkPresent,
	input wire logic calDone,
	// controls to calibration and transmit logic
	output logic calStart,
	output logic oscCenterOnRef,
	output logic oscSweepFull,
	output logic txLockLossForce,
	output logic txRegReset
);
	initial begin
		if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255)
			$error("SOFT_RESET_CYCLES must be 1 to 255");
		// the write decode takes its fields from these positions
		if (`TCC_BIT_MODE_HI != `TCC_BIT_MODE_LO + 1)
			$error("mode field must be two adjacent bits");
		if (`TCC_BIT_FORCE_RECAL > 7 || `TCC_BIT_SOFT_RESET > 7)
			$error("control bits must lie inside the register");
	end

	logic refPresentS;
	logic calDoneS;
	tcc_sync #(.WIDTH(2)) u_sync (
		.clk(ref_clk),
		.resetn(resetn),
		.din({refClkPresent, calDone}),
		.dout({refPresentS, calDoneS})
	);

	tcc_osc_mode_t oscCalMode;
	tcc_cal_state_t calState;
	tcc_cal_state_t next_calState;
	logic softResetBusy;
	logic [7:0] softResetCount;
	logic [2:0] lastTimingMode;
	// timing change that arrived while a calibration was running
	logic recalPending;

	wire logic hit = (regAddr == `TCC_CAL_CFG_ADDR);
	wire logic wrHit = regWrite && hit;
	wire logic swForce = wrHit && regWdata[`TCC_BIT_FORCE_RECAL];
	wire logic tx_soft_reset = wrHit && regWdata[`TCC_BIT_SOFT_RESET];
	// timing mode change recalibrates without software
	wire logic autoRecal = (timingSourceMode != lastTimingMode);
	// a software force while busy is dropped; a pending timing change is not
	wire logic recalReq = (swForce || autoRecal || recalPending) && !tx_soft_reset && !softResetBusy;
	wire logic calBusy = (calState != TCC_CAL_IDLE);
	wire tcc_osc_mode_t wrMode = tcc_osc_mode_t'(regWdata[`TCC_BIT_MODE_HI:`TCC_BIT_MODE_LO]);
	// busy bits read as one until their work is done
	wire logic rdForce = calBusy;
	wire logic rdSoft = softResetBusy;
	// upper nibble is reserved and always reads zero
	wire logic [7:0] readValue = {4'h0, rdForce, oscCalMode, rdSoft};
	wire logic [7:0] next_regRdata = (regRead && hit) ? readValue : 8'h00;
	wire logic armNext = (next_calState == TCC_CAL_ARM);
	// last cycle of the soft reset window
	wire logic softResetDone = softResetBusy && (softResetCount == 8'h00);

	// mode decode; reference sensing only matters in auto mode
	// result bits: centre, sweep, lock-loss force
	function automatic logic [2:0] oscDecode(input tcc_osc_mode_t mode, input logic refSeen);
		logic [2:0] res;
		res = 3'h0;
		unique case (mode)
			TCC_MODE_AUTO: res = refSeen ? 3'h4 : 3'h2;
			TCC_MODE_NOREF: res = 3'h2;
			TCC_MODE_REF: res = 3'h4;
			TCC_MODE_INVALID: res = 3'h1;
		endcase
		return res;
	endfunction

	wire logic [2:0] oscCtl = oscDecode(oscCalMode, refPresentS);
	wire logic modeCenter = oscCtl[2];
	wire logic modeSweep = oscCtl[1];
	wire logic modeInvalid = oscCtl[0];

	// calibration sequencer: arm until the circuits drop done, then wait for it
	always_comb begin
		next_calState = calState;
		unique case (calState)
			TCC_CAL_IDLE: begin
				if (recalReq) next_calState = TCC_CAL_ARM;
			end
			TCC_CAL_ARM: begin
				if (!calDoneS) next_calState = TCC_CAL_WAIT;
			end
			TCC_CAL_WAIT: begin
				if (calDoneS) next_calState = TCC_CAL_IDLE;
			end
			default: next_calState = TCC_CAL_IDLE;
		endcase
		// soft reset returns the force bit to zero with everything else
		if (tx_soft_reset || softResetBusy) next_calState = TCC_CAL_IDLE;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			calState <= TCC_CAL_IDLE;
		end else begin
			calState <= next_calState;
		end
	end

	// start level toward the calibration circuits lasts while armed
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			calStart <= 1'b0;
		end else begin
			calStart <= armNext;
		end
	end

	// timing mode is sampled so a change is seen exactly once
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lastTimingMode <= 3'h0;
		end else begin
			lastTimingMode <= timingSourceMode;
		end
	end

	// a timing change seen mid calibration is kept and served afterwards,
	// otherwise its one-cycle pulse would be lost while the sequencer is busy
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			recalPending <= 1'b0;
		end else if (tx_soft_reset || softResetBusy) begin
			recalPending <= 1'b0;
		end else if (autoRecal && calBusy) begin
			recalPending <= 1'b1;
		end else if (!calBusy) begin
			recalPending <= 1'b0;
		end
	end

	// mode field; a recalibration leaves it untouched
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			oscCalMode <= TCC_MODE_AUTO;
		end else if (tx_soft_reset || softResetBusy) begin
			oscCalMode <= TCC_MODE_AUTO;
		end else if (wrHit) begin
			oscCalMode <= wrMode;
		end
	end

	// soft reset holds the transmit register reset for a fixed time
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			softResetBusy <= 1'b0;
			softResetCount <= 8'h00;
			txRegReset <= 1'b0;
		end else if (tx_soft_reset && !softResetBusy) begin
			softResetBusy <= 1'b1;
			softResetCount <= 8'(SOFT_RESET_CYCLES - 1);
			txRegReset <= 1'b1;
		end else if (softResetBusy) begin
			if (softResetDone) begin
				softResetBusy <= 1'b0;
				txRegReset <= 1'b0;
			end else begin
				softResetCount <= softResetCount - 8'h01;
			end
		end
	end

	// registered outputs toward the oscillator
	// both low only in the invalid mode
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			oscCenterOnRef <= 1'b0;
			oscSweepFull <= 1'b0;
		end else begin
			oscCenterOnRef <= modeCenter;
			oscSweepFull <= modeSweep;
		end
	end

	// lock loss stays forced for as long as the invalid code is held
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			txLockLossForce <= 1'b0;
		end else begin
			txLockLossForce <= modeInvalid;
		end
	end

	// read port: every read is answered, but only this register returns data; other addresses read zero
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= `TCC_CAL_CFG_RESET;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRead;
			regRdata <= next_regRdata;
		end
	end
endmodule
`default_nettype wire

/* tcc_tx_cal_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module tcc_chk #(parameter int SOFT_RESET_CYCLES = 4) (
	// clock, reset and register port
	input wire logic ref_clk, resetn, regWrite, regRead, regRdValid,
	input wire logic [7:0] regAddr, regWdata, regRdata,
	// status and controls
	input wire logic [2:0] timingSourceMode,
	input wire logic refClkPresent, calDone, calStart, oscCenterOnRef, oscSweepFull,
	input wire logic txLockLossForce, txRegReset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	int rc;
	// mode writes count only when no soft reset is requested or running
	wire wrMode = regWrite && regAddr == 8'h88 && !regWdata[0] && !txRegReset;
	always_ff @(posedge ref_clk or negedge resetn)
		if (!resetn) rc <= 0; else rc <= txRegReset ? rc + 1 : 0;
	sequence modeWr(logic [1:0] m);
		wrMode && regWdata[2:1] == m;
	endsequence
	rd_valid_a: assert property (regRead |=> regRdValid)
		else $error("read not answered");
	rsvd_zero_a: assert property (regRdValid |-> regRdata[7:4] == 4'h0)
		else $error("reserved bits set");
	mode_ref_a: assert property (modeWr(2'h2) |-> ##2 oscCenterOnRef && !oscSweepFull)
		else $error("reference mode not centred");
	mode_noref_a: assert property (modeWr(2'h1) |-> ##2 oscSweepFull && !oscCenterOnRef)
		else $error("referenceless mode not sweeping");
	mode_bad_a: assert property (modeWr(2'h3) |-> ##2 txLockLossForce)
		else $error("invalid mode without lock loss");
	srst_start_a: assert property (regWrite && regAddr == 8'h88 && regWdata[0] |=> txRegReset)
		else $error("soft reset not started");
	srst_len_a: assert property ($fell(txRegReset) |-> rc == SOFT_RESET_CYCLES)
		else $error("soft reset length wrong");
	recal_keep_a: assert property ($rose(calStart) |-> !txRegReset)
		else $error("recalibration reset registers");
endmodule
bind tcc_tx_cal_ctrl tcc_chk #(.SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (.*);
`default_nettype wire

/* tx_calibration_reset_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_calibration_reset_control_tb;
	logic ref_clk = 0, resetn = 0, regWrite = 0, regRead = 0, refClkPresent = 1, calDone = 1;
	logic [7:0] regAddr = 8'h88, regWdata = 8'h00, regRdata;
	logic [2:0] timingSourceMode = 3'h0;
	logic regRdValid, calStart, oscCenterOnRef, oscSweepFull, txLockLossForce, txRegReset;
	int n_errors = 0, n_checks = 0, cyc = 0;
	always #20 ref_clk = ~ref_clk;
	tcc_tx_cal_ctrl u_dut (.*);
	task automatic chk(input string what, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge ref_clk) {regAddr, regWdata, regWrite} = {8'h88, d, 1'b1};
		@(negedge ref_clk) regWrite = 0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(negedge ref_clk) {regAddr, regRead} = {a, 1'b1};
		@(negedge ref_clk) regRead = 0;
		chk("valid", 8'(regRdValid), 8'h01);
		chk("rdata", regRdata, exp);
	endtask
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(8'(m * 2));
			cy(4);
			chk("lockloss", 8'(txLockLossForce), 8'(m == 3));
			if (m < 3) chk("osc", 8'({oscCenterOnRef, oscSweepFull}), 8'(m == 1 ? 1 : 2));
			rd(8'h88, 8'(m * 2));
		end
		wr(8'h00);
		refClkPresent = 0;
		cy(6);
		chk("auto sweep", 8'({oscCenterOnRef, oscSweepFull}), 8'h01);
		refClkPresent = 1;
		cy(6);
	endtask
	task automatic t_recal;
		wr(8'h08);
		chk("start", 8'(calStart), 8'h01);
		rd(8'h88, 8'h08);
		calDone = 0;
		cy(4);
		chk("start end", 8'(calStart), 8'h00);
		rd(8'h88, 8'h08);
		calDone = 1;
		cy(4);
		rd(8'h88, 8'h00);
		timingSourceMode = 3'h2;
		cy(2);
		chk("auto start", 8'(calStart), 8'h01);
		calDone = 0;
		cy(4);
		calDone = 1;
		cy(4);
	endtask
	task automatic t_srst;
		wr(8'h04);
		wr(8'h01);
		chk("reset on", 8'(txRegReset), 8'h01);
		rd(8'h88, 8'h01);
		cy(6);
		chk("reset off", 8'(txRegReset), 8'h00);
		rd(8'h88, 8'h00);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// generous ceiling: the full sequence needs fewer than a hundred cycles
	always @(posedge ref_clk) if (++cyc > 2000) begin
		n_errors++;
		report_and_stop;
	end
	initial begin
		cy(4);
		resetn = 1;
		rd(8'h88, 8'h00);
		rd(8'h40, 8'h00);
		t_modes;
		t_recal;
		t_srst;
		report_and_stop;
	end
endmodule
`default_nettype wire
